// file: inc/sadc_params.svh
// Purpose: named constants of the converter control block
// Assumes: core clock of 25 MHz
// Notes:   cycle budgets are counted in converter clock ticks
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CH_OFF       5'h1F
`define SADC_MODE_8       2'h0
`define SADC_MODE_10      2'h1
`define SADC_DIV_1        2'h0
`define SADC_DIV_2        2'h1
`define SADC_DIV_4        2'h2
`define SADC_DIV_8        2'h3
`define SADC_MASK_1       3'h0
`define SADC_MASK_2       3'h1
`define SADC_MASK_4       3'h3
`define SADC_MASK_8       3'h7
`define SADC_DEC_8        6'h09
`define SADC_DEC_10       6'h0B
`define SADC_B8S_FIRST    6'h12
`define SADC_B8S_NEXT     6'h10
`define SADC_B8L_FIRST    6'h26
`define SADC_B8L_NEXT     6'h24
`define SADC_B10S_FIRST   6'h15
`define SADC_B10S_NEXT    6'h13
`define SADC_B10L_FIRST   6'h29
`define SADC_B10L_NEXT    6'h27
`define SADC_CLK_MHZ      25
`define SADC_STARTUP_NS   5000
`define SADC_STARTUP_CYC  (`SADC_STARTUP_NS * `SADC_CLK_MHZ / 1000)
`define SADC_TRIAL_MSB    11'h400
`define SADC_TRIAL_LSB10  11'h001
`define SADC_TRIAL_LSB8   11'h004
`define SADC_CODE_ZERO    11'h000
`define SADC_FULL10       10'h3FF
`define SADC_FULL8        8'hFF
`define SADC_RES_RST      8'h00
`define SADC_HIGH_PAD     6'h00
`endif

// file: inc/sadc_pkg.sv
// Purpose: types shared by the converter control block
// Assumes: nothing beyond the parameter header
// Notes:   field order fixes the packed layout
package sadc_pkg;
   typedef struct packed {
      logic       complete_interrupt_enable;
      logic       continuous_enable;
      logic [4:0] channel_select_field;
   } sadc_scr_t;

   typedef struct packed {
      logic       low_power_config;
      logic [1:0] clock_divide_ratio;
      logic       long_sample_select;
      logic [1:0] mode_sel;
      logic       input_clock_select;
      logic       async_clock_select;
   } sadc_clk_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_SAMPLE,
      ST_CONVERT,
      ST_XFER
   } sadc_state_t;
endpackage

// file: design/sadc_clkdiv.sv
// Purpose: converter clock source select and divide
// Assumes: source ticks are one-cycle strobes on core_clk
// Notes:   divider is held cleared while the converter is idle
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
module sadc_clkdiv
   import sadc_pkg::*;
(
   // clock and reset
   input  wire logic      core_clk,
   input  wire logic      rst,
   // control
   input  wire logic      run,
   input  wire sadc_clk_t cfg,
   // source strobes
   input  wire logic      alt_tick,
   input  wire logic      async_tick,
   // converter clock strobe
   output logic           conv_tick
);
   logic       src_tick;
   logic [2:0] cnt_reg;
   logic [2:0] mask;

   always_comb begin
      if (cfg.async_clock_select) begin
         src_tick = async_tick;
      end else if (cfg.input_clock_select) begin
         src_tick = 1'b1;
      end else begin
         src_tick = alt_tick;
      end
   end

   always_comb begin
      case (cfg.clock_divide_ratio)
         `SADC_DIV_1: mask = `SADC_MASK_1;
         `SADC_DIV_2: mask = `SADC_MASK_2;
         `SADC_DIV_4: mask = `SADC_MASK_4;
         default:     mask = `SADC_MASK_8;
      endcase
   end

   // the run term of conv_tick, not the stopped divider, is what gates the converter clock off when idle
   always_ff @(posedge core_clk) begin
      if (rst || !run) begin
         cnt_reg <= 3'h0;
      end else if (src_tick) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   assign conv_tick = run && src_tick && ((cnt_reg & mask) == mask);
endmodule
`default_nettype wire

// file: design/sadc_ctrl.sv
// Purpose: conversion control of a 10-bit successive approximation converter
// Assumes: comparator output settles within the cycle of each trial code
// Notes:   all software access arrives as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
module sadc_ctrl
   import sadc_pkg::*;
(
   // clock and reset
   input  wire logic      core_clk,
   input  wire logic      rst,
   // software access strobes
   input  wire logic      scr_write,
   input  wire sadc_scr_t scr_wdata,
   input  wire logic      clk_write,
   input  wire sadc_clk_t clk_wdata,
   input  wire logic      rd_high,
   input  wire logic      rd_low,
   // system
   input  wire logic      stop_mode,
   input  wire logic      quad_bus_tick,
   input  wire logic      async_osc_pin,
   // analog side
   input  wire logic      comp_above,
   output logic [4:0]     channel_sel_reg,
   output logic           mux_enable_reg,
   output logic           sample_reg,
   output logic [10:0]    dac_code_reg,
   output logic           async_osc_en_reg,
   output logic           osc_low_range_reg,
   // results and status
   output logic [7:0]     result_high_reg,
   output logic [7:0]     result_low_reg,
   output logic           conversion_complete_flag_reg,
   output logic           interrupt_req_reg,
   output logic           busy_reg
);
   sadc_state_t state_reg;
   sadc_state_t state_next;
   sadc_scr_t   scr_reg;
   sadc_scr_t   scr_next;
   sadc_clk_t   clk_reg;
   sadc_clk_t   clk_next;
   logic        async_meta_reg;
   logic        async_sync_reg;
   logic        async_prev_reg;
   logic        async_tick;
   logic        conv_tick;
   logic        first_reg;
   logic        pend_reg;
   logic [10:0] trial_reg;
   logic [5:0]  sample_cnt_reg;
   logic [7:0]  wait_cnt_reg;
   logic        mode10;
   logic        abort;
   logic        start_req;
   logic        blocked;
   logic        wait_done;
   logic        last_trial;
   logic        sample_done;
   logic [5:0]  budget;
   logic [9:0]  rounded;
   logic        flag_set;
   logic        flag_clr;

   // budget in converter ticks for the current mode and conversion kind
   function automatic logic [5:0] sadc_budget(input logic m10,
                                              input logic lng,
                                              input logic fst);
      logic [5:0] b;
      b = 6'h00;
      case ({m10, lng})
         2'b00:   b = fst ? `SADC_B8S_FIRST  : `SADC_B8S_NEXT;
         2'b01:   b = fst ? `SADC_B8L_FIRST  : `SADC_B8L_NEXT;
         2'b10:   b = fst ? `SADC_B10S_FIRST : `SADC_B10S_NEXT;
         default: b = fst ? `SADC_B10L_FIRST : `SADC_B10L_NEXT;
      endcase
      return b;
   endfunction

   assign scr_next   = scr_write ? scr_wdata : scr_reg;
   assign clk_next   = clk_write ? clk_wdata : clk_reg;
   assign mode10     = (clk_reg.mode_sel == `SADC_MODE_10);
   // stop only kills a conversion that is not on the async oscillator
   assign abort      = scr_write || clk_write ||
                       (stop_mode && !clk_reg.async_clock_select);
   assign start_req  = scr_write &&
                       (scr_wdata.channel_select_field != `SADC_CH_OFF);
   assign blocked    = mode10 && pend_reg;
   assign wait_done  = wait_cnt_reg == 8'(`SADC_STARTUP_CYC - 1);
   assign last_trial = trial_reg ==
                       (mode10 ? `SADC_TRIAL_LSB10 : `SADC_TRIAL_LSB8);
   assign budget     = sadc_budget(mode10, clk_reg.long_sample_select,
                                   first_reg);
   assign sample_done = sample_cnt_reg ==
                        (budget - (mode10 ? `SADC_DEC_10 : `SADC_DEC_8)
                         - 6'h01);
   assign async_tick = async_sync_reg && !async_prev_reg;

   // the extra decision bit below the result width is the rounding bit
   always_comb begin
      if (mode10) begin
         if (dac_code_reg[10:1] == `SADC_FULL10) begin
            rounded = `SADC_FULL10;
         end else begin
            rounded = dac_code_reg[10:1] + {9'h000, dac_code_reg[0]};
         end
      end else begin
         if (dac_code_reg[10:3] == `SADC_FULL8) begin
            rounded = {2'h0, `SADC_FULL8};
         end else begin
            rounded = {2'h0, dac_code_reg[10:3] + {7'h00, dac_code_reg[2]}};
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      if (abort) begin
         state_next = start_req ? ST_START : ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               state_next = ST_IDLE;
            end
            ST_START: begin
               if (!clk_reg.async_clock_select || wait_done) begin
                  state_next = ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (conv_tick && sample_done) begin
                  state_next = ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (conv_tick && last_trial) begin
                  state_next = ST_XFER;
               end
            end
            ST_XFER: begin
               if (scr_reg.continuous_enable || blocked) begin
                  state_next = ST_SAMPLE;
               end else begin
                  state_next = ST_IDLE;
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         scr_reg <= sadc_scr_t'({1'b0, 1'b0, `SADC_CH_OFF});
         clk_reg <= sadc_clk_t'(8'h00);
      end else begin
         scr_reg <= scr_next;
         clk_reg <= clk_next;
      end
   end

   // oscillator pin is unrelated to core_clk
   always_ff @(posedge core_clk) begin
      if (rst) begin
         async_meta_reg <= 1'b0;
         async_sync_reg <= 1'b0;
         async_prev_reg <= 1'b0;
      end else begin
         async_meta_reg <= async_osc_pin;
         async_sync_reg <= async_meta_reg;
         async_prev_reg <= async_sync_reg;
      end
   end

   sadc_clkdiv u_clkdiv (
      .core_clk   (core_clk),
      .rst        (rst),
      .run        (state_reg == ST_SAMPLE || state_reg == ST_CONVERT),
      .cfg        (clk_reg),
      .alt_tick   (quad_bus_tick),
      .async_tick (async_tick),
      .conv_tick  (conv_tick)
   );

   always_ff @(posedge core_clk) begin
      if (rst || state_reg != ST_START) begin
         wait_cnt_reg <= 8'h00;
      end else if (!wait_done) begin
         wait_cnt_reg <= wait_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || state_reg != ST_SAMPLE) begin
         sample_cnt_reg <= 6'h00;
      end else if (conv_tick) begin
         sample_cnt_reg <= sample_cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         first_reg <= 1'b1;
      end else if (start_req) begin
         first_reg <= 1'b1;
      end else if (state_reg == ST_XFER) begin
         first_reg <= !scr_reg.continuous_enable;
      end
   end

   // successive approximation: keep the trial bit if input is above it
   always_ff @(posedge core_clk) begin
      if (rst || state_next == ST_IDLE || state_next == ST_START) begin
         trial_reg    <= `SADC_CODE_ZERO;
         dac_code_reg <= `SADC_CODE_ZERO;
      end else if (state_reg == ST_SAMPLE && state_next == ST_CONVERT) begin
         trial_reg    <= `SADC_TRIAL_MSB;
         dac_code_reg <= `SADC_TRIAL_MSB;
      end else if (state_reg == ST_CONVERT && conv_tick) begin
         trial_reg    <= trial_reg >> 1;
         dac_code_reg <= (comp_above ? dac_code_reg : dac_code_reg & ~trial_reg)
                         | (last_trial ? `SADC_CODE_ZERO : trial_reg >> 1);
      end
   end

   // in 10-bit mode a high read opens a pair that only the low read closes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_reg <= 1'b0;
      end else if (rd_low) begin
         pend_reg <= 1'b0;
      end else if (rd_high && mode10) begin
         pend_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         result_high_reg <= `SADC_RES_RST;
         result_low_reg  <= `SADC_RES_RST;
      end else if (state_reg == ST_XFER && !abort && !blocked) begin
         result_low_reg  <= rounded[7:0];
         result_high_reg <= mode10 ? {`SADC_HIGH_PAD, rounded[9:8]}
                                   : `SADC_RES_RST;
      end
   end

   assign flag_set = state_reg == ST_XFER && !abort && !blocked;
   assign flag_clr = scr_write || rd_low;

   // a completion in the clearing cycle still sets the flag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         conversion_complete_flag_reg <= 1'b0;
      end else if (flag_set) begin
         conversion_complete_flag_reg <= 1'b1;
      end else if (flag_clr) begin
         conversion_complete_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         interrupt_req_reg <= 1'b0;
      end else if (flag_set && scr_next.complete_interrupt_enable) begin
         interrupt_req_reg <= 1'b1;
      end else if (flag_clr || !scr_next.complete_interrupt_enable) begin
         interrupt_req_reg <= 1'b0;
      end
   end

   // analog controls follow the next state so an abort drops them at once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         channel_sel_reg   <= `SADC_CH_OFF;
         mux_enable_reg    <= 1'b0;
         sample_reg        <= 1'b0;
         async_osc_en_reg  <= 1'b0;
         osc_low_range_reg <= 1'b0;
         busy_reg          <= 1'b0;
      end else begin
         channel_sel_reg   <= scr_next.channel_select_field;
         mux_enable_reg    <= state_next != ST_IDLE;
         sample_reg        <= state_next == ST_SAMPLE;
         async_osc_en_reg  <= state_next != ST_IDLE &&
                              clk_next.async_clock_select;
         osc_low_range_reg <= clk_next.low_power_config;
         busy_reg          <= state_next != ST_IDLE;
      end
   end

   // ticks spent since the conversion left its start or transfer phase
   logic [5:0] tick_cnt_reg;
   always_ff @(posedge core_clk) begin
      if (rst || state_reg == ST_START || state_reg == ST_XFER) begin
         tick_cnt_reg <= 6'h00;
      end else if (conv_tick) begin
         tick_cnt_reg <= tick_cnt_reg + 6'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence sw_start_s;
      scr_write && !clk_write &&
      scr_wdata.channel_select_field != `SADC_CH_OFF;
   endsequence
   sequence started_s;
      state_reg == ST_START && busy_reg;
   endsequence

   tick_budget_a: assert property (
      $rose(state_reg == ST_XFER) |-> tick_cnt_reg == budget)
      else $error("conversion length differs from its budget");
   sw_start_a: assert property (sw_start_s |=> started_s)
      else $error("status write did not start a conversion");
   no_start_a: assert property (
      scr_write && scr_wdata.channel_select_field == `SADC_CH_OFF
      |=> state_reg == ST_IDLE && !mux_enable_reg)
      else $error("disabled channel started a conversion");
   clk_abort_a: assert property (
      clk_write && !scr_write |=> !busy_reg && !async_osc_en_reg)
      else $error("clock write did not abort");
   abort_keep_a: assert property (
      abort |=> $stable(result_low_reg) && $stable(result_high_reg))
      else $error("abort altered the results");
   block_a: assert property (
      state_reg == ST_XFER && blocked && !abort
      |=> $stable(result_low_reg) && state_reg == ST_SAMPLE)
      else $error("blocked transfer not handled");
   flag_set_a: assert property (flag_set |=> conversion_complete_flag_reg)
      else $error("completion did not set the flag");
   irq_cause_a: assert property (
      $rose(interrupt_req_reg) |-> conversion_complete_flag_reg &&
      scr_reg.complete_interrupt_enable)
      else $error("interrupt without enabled completion");
   eight_bit_a: assert property (
      flag_set && !mode10 |=> result_high_reg == `SADC_RES_RST)
      else $error("8-bit result reached the high register");
   full_code_a: assert property (
      flag_set && mode10 && dac_code_reg[10:1] == `SADC_FULL10
      |=> {result_high_reg[1:0], result_low_reg} == `SADC_FULL10)
      else $error("full scale did not clamp");
   one_chan_a: assert property (
      mux_enable_reg |-> channel_sel_reg != `SADC_CH_OFF)
      else $error("disabled channel connected");
   startup_a: assert property (
      state_reg == ST_START |-> ##[1:125] state_reg != ST_START)
      else $error("startup wait too long");
endmodule
`default_nettype wire

// file: tb/sadc_comp_model.sv
// Purpose: input mux and comparator stand-in for the conversion control
// Assumes: comparator answers within the core cycle of each trial code
// Notes:   output toggles while unselected so a stale level is never trusted
`timescale 1ns/1ps
`default_nettype none
module sadc_comp_model (
   // clock
   input  wire logic        core_clk,
   // analog side
   input  wire logic [4:0]  channel_sel_reg,
   input  wire logic        mux_enable_reg,
   input  wire logic [10:0] dac_code_reg,
   output logic             comp_above
);
   int   level [32];
   logic toggle_reg;

   initial toggle_reg = 1'b0;

   // a registered answer would lag the code by one decision at divide-by-1
   always @(posedge core_clk) begin
      toggle_reg <= ~toggle_reg;
   end

   assign comp_above = mux_enable_reg ?
                       (level[channel_sel_reg] >= dac_code_reg) :
                       toggle_reg;
endmodule
`default_nettype wire

// file: tb/test_sadc_ctrl.sv
// Purpose: self-checking bench of the conversion control block
// Assumes: comparator stand-in answers within the cycle of each code
// Notes:   time bounds allow three core cycles above each core-clock budget and 136 on the async source
`timescale 1ns/1ps
`default_nettype none
module test_sadc_ctrl
   import sadc_pkg::*;
;
   logic        core_clk, rst, scr_write, clk_write, rd_high, rd_low;
   logic        stop_mode, quad_bus_tick, async_osc_pin, comp_above;
   sadc_scr_t   scr_wdata;
   sadc_clk_t   clk_wdata;
   logic [4:0]  channel_sel_reg;
   logic        mux_enable_reg, sample_reg, async_osc_en_reg;
   logic        osc_low_range_reg, conversion_complete_flag_reg;
   logic        interrupt_req_reg, busy_reg;
   logic [10:0] dac_code_reg;
   logic [7:0]  result_high_reg, result_low_reg;
   logic [2:0]  osc_cnt;
   logic [15:0] last;
   int          miscompares, total_checks, n, m10, lng, dv, vin, ch;
   int          bud [4] = '{18, 38, 21, 41};

   sadc_ctrl u_sadc_ctrl (.core_clk, .rst, .scr_write, .scr_wdata,
      .clk_write, .clk_wdata, .rd_high, .rd_low, .stop_mode, .quad_bus_tick,
      .async_osc_pin, .comp_above, .channel_sel_reg, .mux_enable_reg,
      .sample_reg, .dac_code_reg, .async_osc_en_reg, .osc_low_range_reg,
      .result_high_reg, .result_low_reg, .conversion_complete_flag_reg,
      .interrupt_req_reg, .busy_reg);

   sadc_comp_model u_sadc_comp_model (.core_clk, .channel_sel_reg,
      .mux_enable_reg, .dac_code_reg, .comp_above);

   always #20 core_clk = ~core_clk;

   // quad bus source is irregular on purpose; async pin ticks every 8 cycles
   always @(posedge core_clk) begin
      osc_cnt       <= osc_cnt + 3'h1;
      async_osc_pin <= osc_cnt[2];
      quad_bus_tick <= 1'($urandom % 2);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   function automatic logic [15:0] expect_code(input int v);
      int r;
      int lim;
      r = m10 ? (v + 1) >> 1 : (v + 4) >> 3;
      lim = m10 ? 1023 : 255;
      return 16'(r > lim ? lim : r);
   endfunction

   task automatic cfg(input logic [1:0] src, input logic lp);
      @(posedge core_clk);
      clk_wdata <= {lp, 2'(dv), 1'(lng), 1'b0, 1'(m10), src == 2'h1,
                    src == 2'h2};
      clk_write <= 1'b1;
      @(posedge core_clk);
      clk_write <= 1'b0;
   endtask

   task automatic start(input logic [4:0] c, input logic co, input logic ie);
      u_sadc_comp_model.level[c] = vin;
      @(posedge core_clk);
      scr_wdata <= {ie, co, c};
      scr_write <= 1'b1;
      @(posedge core_clk);
      scr_write <= 1'b0;
   endtask

   task automatic rd(input logic hi, input logic lo);
      @(posedge core_clk);
      rd_high <= hi;
      rd_low  <= lo;
      @(posedge core_clk);
      rd_high <= 1'b0;
      rd_low  <= 1'b0;
   endtask

   task automatic wait_done;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (conversion_complete_flag_reg !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         miscompares++;
         wrap_up();
      end
   endtask

   // single conversion; results are read only once it has completed
   task automatic convert(input logic [1:0] src, input logic ie);
      int b;
      cfg(src, 1'(lng));
      start(5'(ch), 1'b0, ie);
      repeat (2) @(negedge core_clk);
      check({busy_reg, mux_enable_reg, 1'b0, channel_sel_reg},
            {2'h3, 1'b0, 5'(ch)});
      check({async_osc_en_reg, osc_low_range_reg},
            {src == 2'h2, 1'(lng)});
      wait_done();
      check({result_high_reg, result_low_reg}, expect_code(vin));
      check(interrupt_req_reg, ie);
      if (src != 2'h0) begin
         b = bud[m10 * 2 + lng] * (src == 2'h1 ? 1 << dv : 8);
         check(16'(n + 1 >= b && n + 1 <= b + (src == 2'h1 ? 3 : 136)),
               16'h1);
      end
      @(negedge core_clk);
      check({busy_reg, mux_enable_reg, async_osc_en_reg}, 16'h0);
   endtask

   initial begin
      {core_clk, rst, scr_write, clk_write, rd_high, rd_low} = 6'h10;
      {stop_mode, quad_bus_tick, async_osc_pin, osc_cnt} = 6'h00;
      scr_wdata = '0;
      clk_wdata = '0;
      miscompares = 0;
      total_checks = 0;
      void'($urandom(43));
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      check({result_high_reg, result_low_reg}, 16'h0);
      check({channel_sel_reg, busy_reg, conversion_complete_flag_reg},
            16'h7C);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         m10 = i % 2;
         lng = (i / 2) % 2;
         dv = $urandom % 4;
         ch = $urandom % 31;
         vin = i < 2 ? 2047 : i < 4 ? 0 : $urandom % 2048;
         convert(2'h1, 1'(i / 4));
      end
      $display("mode and divide sweep done");
      {m10, lng, dv, ch, vin} = {32'd0, 32'd0, 32'd0, 32'd4, 32'd1500};
      convert(2'h0, 1'b0);
      @(posedge core_clk);
      stop_mode <= 1'b1;
      convert(2'h2, 1'b1);
      @(posedge core_clk);
      stop_mode <= 1'b0;
      $display("clock source test done");
      {m10, vin, ch} = {32'd1, 32'd1000, 32'd3};
      cfg(2'h1, 1'b0);
      start(5'(ch), 1'b1, 1'b0);
      wait_done();
      rd(1'b0, 1'b1);
      wait_done();
      check(16'(n + 1 >= 19 && n + 1 <= 22), 16'h1);
      check({busy_reg, result_high_reg, result_low_reg},
            {1'b1, expect_code(vin)});
      last = {result_high_reg, result_low_reg};
      cfg(2'h1, 1'b0);
      repeat (30) @(negedge core_clk);
      check({busy_reg, mux_enable_reg, sample_reg}, 16'h0);
      check({result_high_reg, result_low_reg}, last);
      $display("continuous and abort test done");
      vin = 700;
      start(5'(ch), 1'b0, 1'b0);
      wait_done();
      last = {result_high_reg, result_low_reg};
      rd(1'b1, 1'b0);
      vin = 300;
      start(5'(ch), 1'b0, 1'b0);
      repeat (60) @(negedge core_clk);
      check({result_high_reg, result_low_reg}, last);
      check({conversion_complete_flag_reg, busy_reg}, 16'h1);
      rd(1'b0, 1'b1);
      wait_done();
      check({result_high_reg, result_low_reg}, expect_code(vin));
      $display("blocking test done");
      start(5'h1F, 1'b0, 1'b0);
      repeat (2) @(negedge core_clk);
      check({busy_reg, channel_sel_reg}, 16'h1F);
      vin = 900;
      start(5'h02, 1'b0, 1'b0);
      start(5'h05, 1'b0, 1'b0);
      repeat (2) @(negedge core_clk);
      check({busy_reg, channel_sel_reg}, 16'h25);
      wait_done();
      check({result_high_reg, result_low_reg}, expect_code(vin));
      start(5'h05, 1'b0, 1'b0);
      @(posedge core_clk);
      stop_mode <= 1'b1;
      repeat (3) @(negedge core_clk);
      check({busy_reg, mux_enable_reg}, 16'h0);
      @(posedge core_clk);
      stop_mode <= 1'b0;
      $display("abort test done");
      start(5'h05, 1'b0, 1'b0);
      repeat (5) @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      check({result_high_reg, result_low_reg}, 16'h0);
      check({channel_sel_reg, busy_reg}, 16'h3E);
      $display("reset abort test done");
      wrap_up();
   end
endmodule
`default_nettype wire
